// >>> logic/bddr_pkg.sv
// constants and carrier types of the burst-of-two ddr sram port
// Notes on behaviour
// - control and read address are taken only on the true input clock rising edge.
// - write data is taken on both true and complementary clock rising edges.
// - both echo strobes toggle all the time, also while read data floats.
// - echo strobe edges line up with read data transitions.
// - while delay-loop bypass is low, the loop is bypassed and its lock cleared.
// - with bypass high the loop locks after the lock time; controller waits. The bench issues writes and reads before lock.
// - with the loop off, read latency is one clock; controller keeps frequency low.
// - output valid flag marks valid read data, aligned to echo strobes.
// - read address is registered on true clock rise and ignored when unselected.
// - narrow option uses low eighteen write data inputs, wide option all.
// - narrow option drives low eighteen read outputs, wide option all.
// - read data bus is driven only for accepted reads.
// - write select low at true clock rise starts a write cycle.
// - read select low at true clock rise starts a read cycle.
// - with the loop locked, first read beat comes two clocks later, second one edge after.
// - write address comes half a cycle later, taken on complementary clock rise.
// - each byte is written only when its mask is low, sampled with its beat.
package bddr_pkg;
  localparam int DATA_W = 36;
  localparam int NARROW_W = 18;
  localparam int ADDR_W = 8;
  localparam int MASK_W = 4;
  localparam int BYTE_W = 9;
  localparam int NARROW_BYTES = 2;
  localparam int LAT_LOCKED = 2;
  localparam int LAT_BYPASS = 1;
  localparam logic [10:0] DLL_LOCK_KCYC = 11'h400;
  localparam logic [10:0] LOCK_CNT_RST = 11'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
  localparam logic [DATA_W-1:0] NARROW_MASK = 36'h0_0003_FFFF;
  localparam logic [DATA_W-1:0] WIDE_MASK = 36'hF_FFFF_FFFF;

  typedef struct packed {
    logic k;
    logic k_n;
    logic read_sel_n;
    logic write_sel_n;
    logic dll_off_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [MASK_W-1:0] mask_n;
  } bddr_pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d0;
    logic [MASK_W-1:0] m0_n;
    logic [DATA_W-1:0] d1;
    logic [MASK_W-1:0] m1_n;
  } bddr_burst_t;

  typedef struct packed {
    logic v;
    logic [ADDR_W-1:0] addr;
  } bddr_rd_t;
endpackage

// >>> logic/bddr_port.sv
// burst-of-two ddr sram device core sampled on ref_clk
`timescale 1ns/1ps
module bddr_port #(
  parameter bit WIDE = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // input clock pair
  input wire logic k_clk,
  input wire logic k_clk_n,
  // command and address
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic [bddr_pkg::ADDR_W-1:0] addr_in,
  // write data
  input wire logic [bddr_pkg::DATA_W-1:0] write_data_in,
  input wire logic [bddr_pkg::MASK_W-1:0] byte_write_mask_n,
  // delay loop
  input wire logic dll_off_n,
  output logic dll_locked,
  // read side
  output logic [bddr_pkg::DATA_W-1:0] read_data_out,
  output logic [bddr_pkg::DATA_W-1:0] read_data_oe,
  output logic echo_strobe_pos,
  output logic echo_strobe_neg,
  output logic output_valid_flag
);
  localparam logic [bddr_pkg::DATA_W-1:0] WMASK =
    WIDE ? bddr_pkg::WIDE_MASK : bddr_pkg::NARROW_MASK;

  bddr_pkg::bddr_pins_t pin_raw, pin_s1, pin_s2;
  logic k_prev_reg, kn_prev_reg, k_rise, kn_rise;

  always_comb begin
    pin_raw.k = k_clk;
    pin_raw.k_n = k_clk_n;
    pin_raw.read_sel_n = read_sel_n;
    pin_raw.write_sel_n = write_sel_n;
    pin_raw.dll_off_n = dll_off_n;
    pin_raw.addr = addr_in;
    pin_raw.data = write_data_in;
    pin_raw.mask_n = byte_write_mask_n;
  end

  // two stages before any logic looks at the pins
  always_ff @(posedge ref_clk) begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      k_prev_reg <= 1'b0;
      kn_prev_reg <= 1'b0;
    end else begin
      k_prev_reg <= pin_s2.k;
      kn_prev_reg <= pin_s2.k_n;
    end
  end

  // a skewed complementary clock still works; only its rising edge counts
  assign k_rise = pin_s2.k && !k_prev_reg;
  assign kn_rise = pin_s2.k_n && !kn_prev_reg;

  // delay loop model
  logic dll_on;
  logic dll_locked_reg, dll_locked_next;
  logic [10:0] lock_cnt_reg, lock_cnt_next;
  assign dll_on = pin_s2.dll_off_n;

  always_comb begin
    lock_cnt_next = lock_cnt_reg;
    dll_locked_next = dll_locked_reg;
    if (!dll_on) begin
      lock_cnt_next = bddr_pkg::LOCK_CNT_RST;
      dll_locked_next = 1'b0;
    end else if (k_rise && !dll_locked_reg) begin
      if (lock_cnt_reg == bddr_pkg::DLL_LOCK_KCYC - 11'h001) begin
        dll_locked_next = 1'b1;
      end
      lock_cnt_next = lock_cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lock_cnt_reg <= bddr_pkg::LOCK_CNT_RST;
      dll_locked_reg <= 1'b0;
    end else begin
      lock_cnt_reg <= lock_cnt_next;
      dll_locked_reg <= dll_locked_next;
    end
  end
  assign dll_locked = dll_locked_reg;

  // write capture: beat 0 on true edge, address and beat 1 on complementary edge
  logic wcap_reg, wcap_next;
  logic [bddr_pkg::DATA_W-1:0] wd0_reg, wd0_next;
  logic [bddr_pkg::MASK_W-1:0] wm0_reg, wm0_next;
  logic wq_v_reg, wq_v_next;
  bddr_pkg::bddr_burst_t wq_reg, wq_next;
  logic fifo_ready;

  always_comb begin
    wcap_next = wcap_reg;
    wd0_next = wd0_reg;
    wm0_next = wm0_reg;
    wq_v_next = wq_v_reg && !fifo_ready;
    wq_next = wq_reg;
    if (k_rise) begin
      wcap_next = !pin_s2.write_sel_n;
      wd0_next = pin_s2.data & WMASK;
      wm0_next = pin_s2.mask_n;
    end
    if (kn_rise && wcap_reg) begin
      wcap_next = 1'b0;
      wq_v_next = 1'b1;
      wq_next.addr = pin_s2.addr;
      wq_next.d0 = wd0_reg;
      wq_next.m0_n = wm0_reg;
      wq_next.d1 = pin_s2.data & WMASK;
      wq_next.m1_n = pin_s2.mask_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wcap_reg <= 1'b0;
      wd0_reg <= bddr_pkg::DATA_RST;
      wm0_reg <= '1;
      wq_v_reg <= 1'b0;
      wq_reg <= '0;
    end else begin
      wcap_reg <= wcap_next;
      wd0_reg <= wd0_next;
      wm0_reg <= wm0_next;
      wq_v_reg <= wq_v_next;
      wq_reg <= wq_next;
    end
  end

  // two-entry buffer in front of the array; a read launch stalls the drain
  bddr_pkg::bddr_burst_t fifo_mem [2];
  logic fifo_wp_reg, fifo_wp_next, fifo_rp_reg, fifo_rp_next;
  logic [1:0] fifo_cnt_reg, fifo_cnt_next;
  logic fifo_valid, drain_ready, push, pop, launch;
  assign fifo_ready = (fifo_cnt_reg != 2'h2);
  assign fifo_valid = (fifo_cnt_reg != 2'h0);
  assign drain_ready = !launch;
  assign push = wq_v_reg && fifo_ready;
  assign pop = fifo_valid && drain_ready;

  always_comb begin
    fifo_wp_next = fifo_wp_reg ^ push;
    fifo_rp_next = fifo_rp_reg ^ pop;
    fifo_cnt_next = fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end else begin
      fifo_wp_reg <= fifo_wp_next;
      fifo_rp_reg <= fifo_rp_next;
      fifo_cnt_reg <= fifo_cnt_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      fifo_mem[fifo_wp_reg] <= wq_reg;
    end
  end

  // storage array: word index is address then beat
  logic [bddr_pkg::DATA_W-1:0] mem [2**(bddr_pkg::ADDR_W+1)];
  bddr_pkg::bddr_burst_t drain_word;
  assign drain_word = fifo_mem[fifo_rp_reg];

  always_ff @(posedge ref_clk) begin
    if (pop) begin
      for (int b = 0; b < bddr_pkg::MASK_W; b++) begin
        if (WIDE || b < bddr_pkg::NARROW_BYTES) begin
          if (!drain_word.m0_n[b]) begin
            mem[{drain_word.addr, 1'b0}][b*bddr_pkg::BYTE_W +: bddr_pkg::BYTE_W] <=
              drain_word.d0[b*bddr_pkg::BYTE_W +: bddr_pkg::BYTE_W];
          end
          if (!drain_word.m1_n[b]) begin
            mem[{drain_word.addr, 1'b1}][b*bddr_pkg::BYTE_W +: bddr_pkg::BYTE_W] <=
              drain_word.d1[b*bddr_pkg::BYTE_W +: bddr_pkg::BYTE_W];
          end
        end
      end
    end
  end

  // read pipeline in true-clock cycles; stage picked by loop mode
  bddr_pkg::bddr_rd_t rp1_reg, rp1_next, rp2_reg, rp2_next, rsel;
  always_comb begin
    rp1_next = rp1_reg;
    rp2_next = rp2_reg;
    if (k_rise) begin
      rp1_next.v = !pin_s2.read_sel_n;
      rp1_next.addr = pin_s2.read_sel_n ? rp1_reg.addr : pin_s2.addr;
      rp2_next = rp1_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rp1_reg <= '0;
      rp2_reg <= '0;
    end else begin
      rp1_reg <= rp1_next;
      rp2_reg <= rp2_next;
    end
  end

  // bypass mode shortens latency; the controller must slow the clock then
  assign rsel = dll_on ? rp2_reg : rp1_reg;
  assign launch = k_rise && rsel.v;

  // output stage; echo strobes and data share one register stage
  logic [bddr_pkg::DATA_W-1:0] q_reg, q_next, hold_reg, hold_next;
  logic valid_reg, valid_next, b1_reg, b1_next;
  logic echo_p_reg, echo_n_reg;

  always_comb begin
    q_next = q_reg;
    hold_next = hold_reg;
    valid_next = valid_reg;
    b1_next = b1_reg;
    if (launch) begin
      q_next = mem[{rsel.addr, 1'b0}] & WMASK;
      hold_next = mem[{rsel.addr, 1'b1}] & WMASK;
      valid_next = 1'b1;
      b1_next = 1'b1;
    end else if (k_rise) begin
      q_next = bddr_pkg::DATA_RST;
      valid_next = 1'b0;
      b1_next = 1'b0;
    end else if (kn_rise && b1_reg) begin
      q_next = hold_reg;
      b1_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q_reg <= bddr_pkg::DATA_RST;
      hold_reg <= bddr_pkg::DATA_RST;
      valid_reg <= 1'b0;
      b1_reg <= 1'b0;
      echo_p_reg <= 1'b0;
      echo_n_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
      hold_reg <= hold_next;
      valid_reg <= valid_next;
      b1_reg <= b1_next;
      echo_p_reg <= pin_s2.k;
      echo_n_reg <= pin_s2.k_n;
    end
  end

  assign read_data_out = q_reg;
  assign read_data_oe = valid_reg ? WMASK : bddr_pkg::DATA_RST;
  assign echo_strobe_pos = echo_p_reg;
  assign echo_strobe_neg = echo_n_reg;
  assign output_valid_flag = valid_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_read_taken;
    k_rise && !pin_s2.read_sel_n;
  endsequence
  sequence s_launch_locked;
    k_rise && dll_on && rp2_reg.v;
  endsequence

  AST_ADDR_TRUE_EDGE: assert property (!k_rise |=> $stable(rp1_reg))
    else $error("read address moved off a true clock edge");
  AST_BEAT0_TRUE_EDGE: assert property (!k_rise |=> $stable(wd0_reg))
    else $error("write beat 0 moved off a true clock edge");
  AST_ECHO_FOLLOWS: assert property (k_rise |=> echo_strobe_pos)
    else $error("echo strobe did not follow the clock");
  AST_ECHO_ALIGN: assert property ($changed(read_data_out) |->
    ($changed(echo_strobe_pos) || $changed(echo_strobe_neg)))
    else $error("read data changed without an echo edge");
  AST_BYPASS_CLEARS: assert property (!dll_on |=> !dll_locked && lock_cnt_reg == 11'h000)
    else $error("bypass did not clear the lock");
  AST_LOCK_TIME: assert property (dll_on && k_rise && !dll_locked &&
    lock_cnt_reg == bddr_pkg::DLL_LOCK_KCYC - 11'h001 |=> dll_locked)
    else $error("lock not reached after lock time");
  AST_LAT_BYPASS: assert property (k_rise && !dll_on && rp1_reg.v |=> output_valid_flag)
    else $error("bypass read not launched after one clock");
  AST_LAT_LOCKED: assert property (s_launch_locked |=> output_valid_flag ##0 b1_reg)
    else $error("locked read not launched after two clocks");
  AST_ADDR_IGNORED: assert property (k_rise && pin_s2.read_sel_n |=> !rp1_reg.v)
    else $error("address taken while deselected");
  AST_NARROW_UPPER: assert property (!WIDE |-> read_data_out[35:18] == 18'h0_0000)
    else $error("narrow option drove upper outputs");
  AST_OE_ONLY_READ: assert property (!output_valid_flag |-> read_data_oe == 36'h0_0000_0000)
    else $error("output driven without a read");
  AST_WRITE_START: assert property (k_rise && !pin_s2.write_sel_n |=> wcap_reg)
    else $error("write select did not start a write");
  AST_READ_START: assert property (s_read_taken |=> rp1_reg.v)
    else $error("read select did not start a read");
  AST_WADDR_COMP: assert property (kn_rise && wcap_reg |=>
    wq_v_reg && wq_reg.addr == $past(pin_s2.addr))
    else $error("write address not taken on complementary edge");
endmodule // bddr_port

// >>> tb/bddr_ctl_model.sv
// memory controller model driving the input clock pair and command pins
`timescale 1ns/1ps
module bddr_ctl_model (
  // input clock pair
  output logic k_clk,
  output logic k_clk_n,
  // command, address and write data
  output logic read_sel_n,
  output logic write_sel_n,
  output logic [bddr_pkg::ADDR_W-1:0] addr_in,
  output logic [bddr_pkg::DATA_W-1:0] write_data_in,
  output logic [bddr_pkg::MASK_W-1:0] byte_write_mask_n,
  // count of true clock rises
  output int kcnt
);
  // pair runs free; pins move a quarter period off each edge so sync stages see them settled
  initial begin
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    addr_in = 8'h00;
    write_data_in = 36'h0;
    byte_write_mask_n = 4'hF;
    k_clk = 1'b0;
    forever #62.5 k_clk = ~k_clk;
  end
  assign k_clk_n = ~k_clk;
  always @(posedge k_clk) kcnt <= kcnt + 1;

  // one k period: selects and beat0 before k rises, write address and beat1 before k_n rises
  task automatic cycle(input logic rd, input logic wr,
      input logic [bddr_pkg::ADDR_W-1:0] ra, input logic [bddr_pkg::ADDR_W-1:0] wa,
      input logic [bddr_pkg::DATA_W-1:0] d0, input logic [bddr_pkg::DATA_W-1:0] d1,
      input logic [bddr_pkg::MASK_W-1:0] m0, input logic [bddr_pkg::MASK_W-1:0] m1);
    @(posedge k_clk_n);
    #31;
    read_sel_n = ~rd;
    write_sel_n = ~wr;
    addr_in = ra;
    write_data_in = d0;
    byte_write_mask_n = m0;
    @(posedge k_clk);
    #31;
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    addr_in = wa;
    write_data_in = d1;
    byte_write_mask_n = m1;
  endtask
endmodule // bddr_ctl_model

// >>> tb/burst2_ddr_sram_port_tb.sv
// self-checking bench of the burst-of-two ddr sram port, wide and narrow options
`timescale 1ns/1ps
module burst2_ddr_sram_port_tb;
  typedef struct {int k; logic [35:0] w0; logic [35:0] w1;} bddr_exp_t;
  logic ref_clk;
  logic resetn;
  logic dll_off_n;
  wire k_clk, k_clk_n, read_sel_n, write_sel_n;
  wire [7:0] addr_in;
  wire [35:0] write_data_in;
  wire [3:0] byte_write_mask_n;
  wire [35:0] rdo [2];
  wire [35:0] oe [2];
  wire [1:0] lock, vld, pos, neg;
  wire [3:0] ec = {neg[1], pos[1], neg[0], pos[0]};
  logic [3:0] ec_q = 4'h0;
  int idle [4];
  int kcnt;
  int failures = 0;
  int tests_run = 0;
  logic [35:0] mem [int];
  bddr_exp_t expq [$];

  bddr_ctl_model ctl (.k_clk(k_clk), .k_clk_n(k_clk_n), .read_sel_n(read_sel_n),
    .write_sel_n(write_sel_n), .addr_in(addr_in), .write_data_in(write_data_in),
    .byte_write_mask_n(byte_write_mask_n), .kcnt(kcnt));

  // instance 0 is the wide option, instance 1 the narrow one, on the same pins
  for (genvar i = 0; i < 2; i++) begin : g
    bddr_port #(.WIDE(i == 0)) dut (.ref_clk(ref_clk), .resetn(resetn), .k_clk(k_clk),
      .k_clk_n(k_clk_n), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
      .addr_in(addr_in), .write_data_in(write_data_in),
      .byte_write_mask_n(byte_write_mask_n), .dll_off_n(dll_off_n), .dll_locked(lock[i]),
      .read_data_out(rdo[i]), .read_data_oe(oe[i]), .echo_strobe_pos(pos[i]),
      .echo_strobe_neg(neg[i]), .output_valid_flag(vld[i]));
  end

  function automatic logic [35:0] wid(int i);
    return i ? bddr_pkg::NARROW_MASK : bddr_pkg::WIDE_MASK;
  endfunction

  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one k period through the controller; the model applies writes before reading
  task automatic op(input bit rd, input bit wr, input bit full, input logic [7:0] ra,
      input logic [7:0] wa);
    logic [35:0] d [2];
    logic [3:0] m [2];
    bddr_exp_t e;
    for (int b = 0; b < 2; b++) begin
      d[b] = 36'({$urandom, $urandom});
      m[b] = full ? 4'h0 : 4'($urandom);
    end
    ctl.cycle(rd, wr, ra, wa, d[0], d[1], m[0], m[1]);
    for (int b = 0; b < 2; b++)
      for (int y = 0; y < 4; y++)
        if (wr && !m[b][y]) mem[{wa, b[0]}][9*y+:9] = d[b][9*y+:9];
    if (rd) begin
      e.k = kcnt + (dll_off_n ? 2 : 1);
      e.w0 = mem[{ra, 1'b0}];
      e.w1 = mem[{ra, 1'b1}];
      expq.push_back(e);
    end
  endtask

  // reads every other cycle, writes on read cycles and at random in between; a later write never hits a pending read
  task automatic traffic(int n);
    logic [7:0] a;
    repeat (n) begin
      a = 8'($urandom % 8);
      op(1, 1, 0, a, 8'($urandom % 8));
      op(0, 1'($urandom), 0, 8'($urandom), a ^ 8'h01);
    end
    repeat (4) op(0, 0, 0, 8'($urandom), 8'($urandom));
    check("reads_left", 36'h0, 36'(expq.size()));
  endtask

  always @(negedge ref_clk) begin
    for (int j = 0; j < 4; j++) begin
      idle[j] = (!resetn || ec[j] !== ec_q[j]) ? 0 : idle[j] + 1;
      if (idle[j] > 10) check("echo_run", 36'h1, 36'h0);
    end
    for (int i = 0; i < 2; i++)
      if (!vld[i]) check("oe_idle", 36'h0, oe[i]);
    if (resetn && ec[0] && !ec_q[0]) begin
      if (vld[0] && expq.size() == 0) check("read_spurious", 36'h0, 36'h1);
      else if (expq.size() > 0 && (vld[0] || expq[0].k <= kcnt)) begin
        check("read_kcycle", 36'(expq[0].k), 36'(kcnt));
        for (int i = 0; i < 2; i++) begin
          check("beat0", expq[0].w0 & wid(i), rdo[i]);
          check("data_oe", wid(i), oe[i]);
          check("valid", 36'h1, 36'(vld[i]));
        end
        if (!vld[0]) void'(expq.pop_front());
      end
    end
    if (resetn && vld[0] && ec[1] && !ec_q[1] && expq.size() > 0) begin
      for (int i = 0; i < 2; i++) check("beat1", expq[0].w1 & wid(i), rdo[i]);
      void'(expq.pop_front());
    end
    ec_q = ec;
  end

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // a hang ends in the closing report
  initial begin
    #600us;
    failures++;
    test_done();
  end

  initial begin
    void'($urandom(32'h3DC0));
    resetn = 1'b0;
    dll_off_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    check("lock_early", 36'h0, 36'(lock));
    for (int a = 0; a < 8; a++) op(0, 1, 1, 8'($urandom), 8'(a));
    repeat (4) op(0, 0, 0, 8'($urandom), 8'($urandom));
    traffic(12);
    repeat (950) @(posedge k_clk);
    check("lock_wait", 36'h0, 36'(lock));
    repeat (80) @(posedge k_clk);
    check("lock_done", 36'h3, 36'(lock));
    traffic(12);
    @(posedge ref_clk);
    #1;
    dll_off_n = 1'b0;
    repeat (4) op(0, 0, 0, 8'($urandom), 8'($urandom));
    check("lock_clear", 36'h0, 36'(lock));
    traffic(12);
    test_done();
  end
endmodule // burst2_ddr_sram_port_tb
